// File: core/fpsc_frontend_regs.sv
`timescale 1ns/1ps
// Overview of operation
// - Three-bit level index points into an eight-entry amplifier level table.
// - Keyed modulation: a one symbol uses the table entry at the index.
// - Keyed modulation: a zero symbol uses table entry zero once ramped up.
// - Steps entries zero..index for start/end ramps in all formats; keyed symbols switch entries directly.
// - Pump calibration stage skipped when its two-bit enable is zero; resets to 10.
// - Four-bit pump calibration result, reset 1001, current exponential in value.
// - Receive trim register holds four two-bit trims resetting 01,01,01,10.
// - Transmit register holds buffer trim at 5:4 reset 1 and index reset 0.
module fpsc_frontend_regs
  import fpsc_pkg::*;
#(
  parameter int TABLE_DEPTH = 8,
  parameter int RAMP_STEP_CYC = FPSC_RAMP_STEP_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic table_wr,
  input wire logic [2:0] table_idx,
  input wire logic [7:0] table_wdata,
  input wire logic tx_active,
  input wire logic keyed_mode,
  input wire logic tx_symbol,
  input wire logic cal_result_we,
  input wire logic [3:0] cal_result,
  output logic [7:0] amp_level,
  output logic ramp_done,
  output logic [1:0] low_noise_amp_trim,
  output logic [1:0] amp_to_mixer_trim,
  output logic [1:0] rx_osc_buffer_trim,
  output logic [1:0] mixer_trim,
  output logic [1:0] tx_osc_buffer_trim,
  output logic pump_cal_stage_enable,
  output logic [3:0] synth_cal_word_hi,
  output logic [1:0] synth_cal_config
);
  // The table index is three bits wide, so only eight entries can ever be addressed
  if (TABLE_DEPTH != 8) begin : g_bad_depth
    $error("level table must have eight entries");
  end
  // The step counter is sixteen bits wide
  if (RAMP_STEP_CYC < 1 || RAMP_STEP_CYC > 65536) begin : g_bad_step
    $error("ramp step must be 1 to 65536 cycles");
  end

  // Shared by the write enables and the read mux
  function automatic logic reg_hit(input logic [5:0] addr, input logic [5:0] target);
    return addr == target;
  endfunction

  logic [7:0] rx_frontend_trim_ff;
  logic [7:0] tx_frontend_config_ff;
  logic [7:0] synth_pump_calibration_ff;
  logic pump_enable_ff;
  logic [7:0] reg_rdata_ff;
  logic [7:0] amp_level_ff;
  logic ramp_done_ff;
  fpsc_ramp_type ramp_ff;
  logic [2:0] step_ff;
  logic [15:0] tick_ff;
  fpsc_ramp_type nxt_ramp;
  logic [2:0] nxt_step;
  logic [15:0] nxt_tick;
  logic [7:0] nxt_rx_trim;
  logic [7:0] nxt_tx_cfg;
  logic [7:0] nxt_pump_cal;
  logic nxt_pump_enable;
  logic [7:0] nxt_amp_level;
  logic [FPSC_RX_TRIM_W-1:0] rx_trim_field [FPSC_RX_TRIM_CNT];

  wire hit_rx = reg_hit(reg_addr, FPSC_ADDR_RX_TRIM);
  wire hit_tx = reg_hit(reg_addr, FPSC_ADDR_TX_CFG);
  wire hit_cal = reg_hit(reg_addr, FPSC_ADDR_PUMP_CAL);
  wire wr_rx = reg_wr && hit_rx;
  wire wr_tx = reg_wr && hit_tx;
  wire wr_cal = reg_wr && hit_cal;
  wire [2:0] amp_level_index = tx_frontend_config_ff[FPSC_IDX_LSB +: 3];
  wire tick = tick_ff == 16'(RAMP_STEP_CYC - 1);
  wire [2:0] sel_idx;
  wire [7:0] table_q;
  wire [7:0] nxt_rdata;

  assign nxt_rdata = hit_rx ? rx_frontend_trim_ff :
                     hit_tx ? tx_frontend_config_ff :
                     hit_cal ? synth_pump_calibration_ff : 8'h00;
  assign nxt_rx_trim = wr_rx ? reg_wdata : rx_frontend_trim_ff;
  // Reserved bits are dropped on the way in, so reads return zero there
  assign nxt_tx_cfg = wr_tx ? (reg_wdata & FPSC_TX_CFG_MASK) : tx_frontend_config_ff;
  assign nxt_pump_enable = nxt_pump_cal[FPSC_CAL_EN_LSB +: 2] != FPSC_CAL_EN_OFF;

  // Host write wins over an internal result in the same cycle, so restored values stick
  always_comb begin
    nxt_pump_cal = synth_pump_calibration_ff;
    if (wr_cal) nxt_pump_cal = reg_wdata;
    else if (cal_result_we) nxt_pump_cal[FPSC_CAL_RES_LSB +: 4] = cal_result;
  end

  fpsc_level_table #(.DEPTH(TABLE_DEPTH), .AW(3)) u_table (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(table_wr),
    .wr_idx(table_idx),
    .wr_data(table_wdata),
    .rd_idx(sel_idx),
    .rd_data(table_q)
  );

  // Ramp controller; keyed symbols choose the entry at the index or entry zero once ramped up
  always_comb begin
    nxt_ramp = ramp_ff;
    nxt_step = step_ff;
    case (ramp_ff)
      FPSC_IDLE: begin
        nxt_step = 3'h0;
        if (tx_active) nxt_ramp = FPSC_UP;
      end
      FPSC_UP: begin
        if (!tx_active) nxt_ramp = FPSC_DOWN;
        else if (step_ff >= amp_level_index) nxt_ramp = FPSC_HOLD;
        else if (tick) nxt_step = step_ff + 3'h1;
      end
      FPSC_HOLD: begin
        nxt_step = amp_level_index;
        if (!tx_active) nxt_ramp = FPSC_DOWN;
      end
      FPSC_DOWN: begin
        if (tx_active) nxt_ramp = FPSC_UP;
        else if (step_ff == 3'h0) nxt_ramp = FPSC_IDLE;
        else if (tick) nxt_step = step_ff - 3'h1;
      end
      default: begin
        nxt_ramp = FPSC_IDLE;
        nxt_step = 3'h0;
      end
    endcase
  end

  // Keyed hold: '1' uses index, '0' uses entry zero
  assign sel_idx = (ramp_ff == FPSC_HOLD && keyed_mode) ?
                   (tx_symbol ? amp_level_index : 3'h0) : step_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_frontend_trim_ff <= FPSC_RST_RX_TRIM;
    end else begin
      rx_frontend_trim_ff <= nxt_rx_trim;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_frontend_config_ff <= FPSC_RST_TX_CFG;
    end else begin
      tx_frontend_config_ff <= nxt_tx_cfg;
    end
  end

  // Enable flag is its own flop so the output needs no gate after the register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      synth_pump_calibration_ff <= FPSC_RST_PUMP_CAL;
      pump_enable_ff <= FPSC_RST_PUMP_CAL[FPSC_CAL_EN_LSB +: 2] != FPSC_CAL_EN_OFF;
    end else begin
      synth_pump_calibration_ff <= nxt_pump_cal;
      pump_enable_ff <= nxt_pump_enable;
    end
  end

  // Counter is held at zero in idle and hold, so a ramp entered from either gets a full first step
  assign nxt_tick = (tick || nxt_step != step_ff || ramp_ff == FPSC_HOLD || ramp_ff == FPSC_IDLE) ?
                    16'h0000 : tick_ff + 16'h0001;
  assign nxt_amp_level = (ramp_ff == FPSC_IDLE) ? 8'h00 : table_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ramp_ff <= FPSC_IDLE;
      step_ff <= 3'h0;
      tick_ff <= 16'h0000;
    end else begin
      ramp_ff <= nxt_ramp;
      step_ff <= nxt_step;
      tick_ff <= nxt_tick;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      amp_level_ff <= 8'h00;
      ramp_done_ff <= 1'b0;
      reg_rdata_ff <= 8'h00;
    end else begin
      amp_level_ff <= nxt_amp_level;
      ramp_done_ff <= nxt_ramp == FPSC_HOLD;
      if (reg_rd) reg_rdata_ff <= nxt_rdata;
    end
  end

  // One loop serves the four receive trims; field zero sits at the bottom
  for (genvar g = 0; g < FPSC_RX_TRIM_CNT; g++) begin : g_rx_trim
    assign rx_trim_field[g] = rx_frontend_trim_ff[g * FPSC_RX_TRIM_W +: FPSC_RX_TRIM_W];
  end

  assign reg_rdata = reg_rdata_ff;
  assign amp_level = amp_level_ff;
  assign ramp_done = ramp_done_ff;
  assign low_noise_amp_trim = rx_trim_field[3];
  assign amp_to_mixer_trim = rx_trim_field[2];
  assign rx_osc_buffer_trim = rx_trim_field[1];
  assign mixer_trim = rx_trim_field[0];
  assign tx_osc_buffer_trim = tx_frontend_config_ff[FPSC_TXBUF_LSB +: 2];
  assign pump_cal_stage_enable = pump_enable_ff;
  assign synth_cal_word_hi = synth_pump_calibration_ff[FPSC_CAL_RES_LSB +: 4];
  assign synth_cal_config = synth_pump_calibration_ff[FPSC_CAL_CFG_LSB +: 2];
endmodule // fpsc_frontend_regs

// File: core/fpsc_pkg.sv
package fpsc_pkg;
  localparam logic [5:0] FPSC_ADDR_RX_TRIM = 6'h21;
  localparam logic [5:0] FPSC_ADDR_TX_CFG = 6'h22;
  localparam logic [5:0] FPSC_ADDR_PUMP_CAL = 6'h23;
  localparam logic [7:0] FPSC_RST_RX_TRIM = 8'h56;
  localparam logic [7:0] FPSC_RST_TX_CFG = 8'h10;
  localparam logic [7:0] FPSC_RST_PUMP_CAL = 8'hA9;
  localparam logic [7:0] FPSC_TX_CFG_MASK = 8'h37;
  localparam logic [7:0] FPSC_RST_TABLE_ENTRY = 8'h00;
  localparam int FPSC_IDX_LSB = 0;
  localparam int FPSC_TXBUF_LSB = 4;
  localparam int FPSC_CAL_RES_LSB = 0;
  localparam int FPSC_CAL_EN_LSB = 4;
  localparam int FPSC_CAL_CFG_LSB = 6;
  localparam int FPSC_RX_TRIM_W = 2;
  localparam int FPSC_RX_TRIM_CNT = 4;
  localparam logic [1:0] FPSC_CAL_EN_OFF = 2'h0;
  localparam int FPSC_RAMP_STEP_NS = 100;
  localparam int FPSC_CLK_NS = 10;
  localparam int FPSC_RAMP_STEP_CYC = (FPSC_RAMP_STEP_NS + FPSC_CLK_NS - 1) / FPSC_CLK_NS;
  typedef enum logic [1:0] {FPSC_IDLE, FPSC_UP, FPSC_HOLD, FPSC_DOWN} fpsc_ramp_type;
endpackage

// File: core/fpsc_level_table.sv
`timescale 1ns/1ps
module fpsc_level_table
  import fpsc_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_idx,
  output logic [7:0] rd_data
);
  logic [7:0] mem_ff [DEPTH];
  if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
    $error("table depth exceeds index range");
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) mem_ff[i] <= FPSC_RST_TABLE_ENTRY;
    end else if (wr_en) begin
      mem_ff[wr_idx] <= wr_data;
    end
  end
  assign rd_data = mem_ff[rd_idx];
endmodule // fpsc_level_table

// File: bench/fpsc_regs_assertions.sv
`timescale 1ns/1ps
module fpsc_regs_chk
  import fpsc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic tx_active,
  input wire logic cal_result_we,
  input wire logic [3:0] cal_result,
  input wire logic ramp_done,
  input wire logic [1:0] low_noise_amp_trim,
  input wire logic [1:0] amp_to_mixer_trim,
  input wire logic [1:0] rx_osc_buffer_trim,
  input wire logic [1:0] mixer_trim,
  input wire logic [1:0] tx_osc_buffer_trim,
  input wire logic pump_cal_stage_enable,
  input wire logic [3:0] synth_cal_word_hi,
  input wire logic [1:0] synth_cal_config
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire w21 = reg_wr && reg_addr == FPSC_ADDR_RX_TRIM;
  wire w22 = reg_wr && reg_addr == FPSC_ADDR_TX_CFG;
  wire w23 = reg_wr && reg_addr == FPSC_ADDR_PUMP_CAL;
  wire hit = reg_addr inside {FPSC_ADDR_RX_TRIM, FPSC_ADDR_TX_CFG, FPSC_ADDR_PUMP_CAL};
  // Isolated reads only, so the answer cannot be overtaken
  property p_tx_rd; reg_rd && reg_addr == FPSC_ADDR_TX_CFG ##1 !reg_rd |=> (reg_rdata & ~FPSC_TX_CFG_MASK) == 8'h00;
  endproperty
  a_tx_rd: assert property (p_tx_rd) else $error("unused tx config bits read nonzero");
  property p_unmap; reg_rd && !hit ##1 !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
  property p_pump; w23 |=> pump_cal_stage_enable == ($past(reg_wdata[5:4]) != FPSC_CAL_EN_OFF); endproperty
  a_pump: assert property (p_pump) else $error("pump stage enable wrong");
  property p_word_wr; w23 |=> synth_cal_word_hi == $past(reg_wdata[3:0]); endproperty
  a_word_wr: assert property (p_word_wr) else $error("cal word not written");
  property p_word_res; cal_result_we && !w23 |=> synth_cal_word_hi == $past(cal_result); endproperty
  a_word_res: assert property (p_word_res) else $error("cal result not stored");
  property p_txbuf; w22 |=> tx_osc_buffer_trim == $past(reg_wdata[5:4]); endproperty
  a_txbuf: assert property (p_txbuf) else $error("tx buffer trim wrong");
  property p_rxtrim;
    w21 |=> {low_noise_amp_trim, amp_to_mixer_trim, rx_osc_buffer_trim, mixer_trim} == $past(reg_wdata);
  endproperty
  a_rxtrim: assert property (p_rxtrim) else $error("rx trims wrong");
  property p_cal_cfg; w23 |=> synth_cal_config == $past(reg_wdata[7:6]); endproperty
  a_cal_cfg: assert property (p_cal_cfg) else $error("cal config not written");
  property p_ramp; $rose(tx_active) |=> !ramp_done; endproperty
  a_ramp: assert property (p_ramp) else $error("ramp done without ramp");
  c_ramp: cover property (tx_active && ramp_done);
  c_res: cover property (cal_result_we && !w23);
  c_unmap: cover property (reg_rd && !hit);
endmodule // fpsc_regs_chk
bind fpsc_frontend_regs fpsc_regs_chk chk_u (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tx_active(tx_active),
  .cal_result_we(cal_result_we), .cal_result(cal_result), .ramp_done(ramp_done),
  .low_noise_amp_trim(low_noise_amp_trim), .amp_to_mixer_trim(amp_to_mixer_trim),
  .rx_osc_buffer_trim(rx_osc_buffer_trim), .mixer_trim(mixer_trim), .tx_osc_buffer_trim(tx_osc_buffer_trim),
  .pump_cal_stage_enable(pump_cal_stage_enable), .synth_cal_word_hi(synth_cal_word_hi),
  .synth_cal_config(synth_cal_config));

// File: bench/fpsc_host.sv
`timescale 1ns/1ps
module fpsc_host (
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic [5:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  // Saved cal words go back through wr between hops config loaded via wr first
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
endmodule // fpsc_host

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench
  import fpsc_pkg::*;
;
  logic clk = 0, rst_n = 0, reg_wr, reg_rd, table_wr = 0, tx_active = 0, keyed_mode = 0, tx_symbol = 0;
  logic cal_result_we = 0, ramp_done;
  logic [5:0] reg_addr, a;
  logic [7:0] reg_wdata, reg_rdata, table_wdata = 0, amp_level, got, d, tbl [8];
  logic [3:0] cal_result = 0;
  logic [2:0] table_idx = 0;
  int n_mismatch = 0, cmp_count = 0, cyc = 0, seed = 32'h0E9ACCED;
  always #5 clk = ~clk;
  fpsc_host host_u (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));
  // Step of one cycle keeps ramps short
  fpsc_frontend_regs #(.RAMP_STEP_CYC(1)) dut_u (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .table_wr(table_wr), .table_idx(table_idx),
    .table_wdata(table_wdata), .tx_active(tx_active), .keyed_mode(keyed_mode), .tx_symbol(tx_symbol),
    .cal_result_we(cal_result_we), .cal_result(cal_result), .amp_level(amp_level), .ramp_done(ramp_done),
    .low_noise_amp_trim(), .amp_to_mixer_trim(),
    .rx_osc_buffer_trim(), .mixer_trim(), .tx_osc_buffer_trim(), .pump_cal_stage_enable(),
    .synth_cal_word_hi(), .synth_cal_config());
  function automatic logic [7:0] exp_rd(input logic [5:0] ad, input logic [7:0] v);
    return ad == FPSC_ADDR_TX_CFG ? v & FPSC_TX_CFG_MASK : v;
  endfunction
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk) rst_n = 1;
    for (int i = 0; i < 3; i++) begin
      host_u.rd(6'(FPSC_ADDR_RX_TRIM + i), got);
      chk(i == 0 ? FPSC_RST_RX_TRIM : i == 1 ? FPSC_RST_TX_CFG : FPSC_RST_PUMP_CAL, got);
    end
    // All ones and all zeros first, then random
    for (int i = 0; i < 24; i++) begin
      a = 6'(FPSC_ADDR_RX_TRIM + i % 3);
      d = i < 3 ? 8'hFF : i < 6 ? 8'h00 : 8'($random(seed));
      host_u.wr(a, d);
      host_u.rd(a, got);
      chk(exp_rd(a, d), got);
    end
    host_u.wr(6'h30, 8'hFF);
    host_u.rd(6'h30, got);
    chk(8'h00, got);
    d = 8'($random(seed));
    @(negedge clk) {cal_result_we, cal_result} = {1'b1, d[3:0]};
    @(negedge clk) cal_result_we = 0;
    host_u.rd(FPSC_ADDR_PUMP_CAL, got);
    chk({4'h0, d[3:0]}, {4'h0, got[3:0]});
    // Result and host restore in one cycle: the restored value is kept
    d = 8'($random(seed));
    @(negedge clk) {cal_result_we, cal_result} = {1'b1, ~d[3:0]};
    host_u.wr(FPSC_ADDR_PUMP_CAL, d);
    cal_result_we = 0;
    host_u.rd(FPSC_ADDR_PUMP_CAL, got);
    chk(d, got);
    for (int i = 0; i < 8; i++) begin
      tbl[i] = 8'($random(seed)) | 8'h01;
      @(negedge clk) {table_wr, table_idx, table_wdata} = {1'b1, 3'(i), tbl[i]};
    end
    @(negedge clk) table_wr = 0;
    for (int k = 0; k < 3; k++) begin
      d = k == 0 ? 8'h07 : k == 1 ? 8'h00 : 8'($random(seed)) & 8'h07;
      host_u.wr(FPSC_ADDR_TX_CFG, d);
      {tx_active, keyed_mode, tx_symbol} = 3'b111;
      @(negedge clk) chk(8'h00, amp_level);
      for (int s = 0; s <= int'(d[2:0]); s++) begin
        @(negedge clk) chk(tbl[s], amp_level);
      end
      chk(8'h01, {7'h00, ramp_done});
      for (int w = 0; w < 40 && ramp_done !== 1'b1; w++) @(negedge clk);
      chk(tbl[d[2:0]], amp_level);
      @(negedge clk) tx_symbol = 0;
      repeat (3) @(negedge clk);
      chk(tbl[0], amp_level);
      keyed_mode = 0;
      repeat (3) @(negedge clk);
      chk(tbl[d[2:0]], amp_level);
      tx_active = 0;
      repeat (20) @(negedge clk);
      chk(8'h00, amp_level);
    end
    // Reset in mid-run brings the level output, ramp done and the receive trim register back
    host_u.wr(FPSC_ADDR_RX_TRIM, 8'h00);
    tx_active = 1;
    repeat (12) @(negedge clk);
    rst_n = 0;
    @(negedge clk) chk(8'h00, amp_level);
    tx_active = 0;
    rst_n = 1;
    host_u.rd(FPSC_ADDR_RX_TRIM, got);
    chk(FPSC_RST_RX_TRIM, got);
    chk(8'h00, {7'h00, ramp_done});
    wrap_up();
  end
endmodule // testbench
